// >>> logic/tmo_pkg.sv
`default_nettype none

package tmo_pkg;

  // Sequencer states of the one-shot timer
  typedef enum logic [1:0] {
    TMO_IDLE = 2'b00, // Waiting for a start condition
    TMO_RUN = 2'b01,  // Counting toward the period value
    TMO_HOLD = 2'b10, // Held at zero after a limit reset edge
    TMO_DONE = 2'b11  // Monostable finished, run-enable still set
  } tmo_state_e;

  // Register data word
  typedef logic [7:0] tmo_byte_t;

endpackage

`default_nettype wire

// >>> logic/tmo_regs.svh
`ifndef TMO_REGS_SVH
`define TMO_REGS_SVH

// Register word addresses on the plain register port
`define TMO_ADDR_CTRL 3'h0
`define TMO_ADDR_PERIOD 3'h1
`define TMO_ADDR_PULSE 3'h2
`define TMO_ADDR_COUNT 3'h3
`define TMO_ADDR_STATUS 3'h4

// Control register fields
`define TMO_CTRL_ON_BIT 7
`define TMO_CTRL_MODE_HI 4
`define TMO_CTRL_MODE_LO 0

// Status register fields
`define TMO_STAT_PWM_BIT 7
`define TMO_STAT_ST_HI 1
`define TMO_STAT_ST_LO 0

// Reset values
`define TMO_RST_MODE 5'h00
`define TMO_RST_PERIOD 8'hff
`define TMO_RST_PULSE 8'h00

// Operating mode codes
`define TMO_MODE_SW_OS 5'h08
`define TMO_MODE_EOS_RISE 5'h09
`define TMO_MODE_EOS_ANY 5'h0b
`define TMO_MODE_EHL_RISE 5'h0c
`define TMO_MODE_EHL_FALL 5'h0d
`define TMO_MODE_LES_LOW 5'h0e
`define TMO_MODE_LES_HIGH 5'h0f
`define TMO_MODE_MONO_RISE 5'h11
`define TMO_MODE_MONO_ANY 5'h13
`define TMO_MODE_LHL_LOW 5'h16
`define TMO_MODE_LHL_HIGH 5'h17

// Restart delay after a hardware-limit reset edge, in timer clocks
`define TMO_HL_DELAY 2

`endif

// >>> logic/tmo_timer.sv
// What this block does
// - Software one-shot: period match clears count and enable
// - Software PWM: on at enable, off at width
// - New cycle only after enable set post-match
// - Edge one-shot starts on chosen edge, match clears
// - After software halt, fresh edge needed to resume
// - Edge PWM: on at edge, off at width
// - Limit one-shot: later edges reset, resume two clocks
// - Limit one-shot: match clears; edges ignored when off
// - Limit PWM on at start and reset edges
// - Level-reset modes hold zero; start on active edge
// - Level-reset modes clear at match; edge needed again
// - Level-reset PWM on at edge, not at match
// - Monostable starts on chosen edge, stops at match
// - Monostable PWM on at edge only, edges ignored
// - Level limit holds zero; enable and release start
// - Level limit clears at match, holds until both
// - Level limit PWM on by whichever event starts
// - One-shot: after match, enable cleared, count zero
// - Monostable: after match, count zero, enable kept
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "tmo_regs.svh"

module tmo_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic external_reset_signal,
  output logic pwm_drive,
  output logic [7:0] count_value
);

  // Software-visible control state
  logic on_r;                 // Run-enable bit
  logic [4:0] mode_r;         // Operating mode code
  logic [7:0] period_value_r; // Period value
  logic [7:0] pulse_width_r;  // Pulse-width value
  logic [7:0] count_r;        // Timer count
  logic pwm_r;                // PWM drive toward the compare unit
  tmo_pkg::tmo_state_e st_r;  // Sequencer state
  logic [1:0] hold_r;         // Remaining restart-delay clocks
  logic [7:0] rdata_r;        // Registered read data

  // External signal synchroniser and filtered level
  logic ers_s1_r;
  logic ers_s2_r;
  logic ers_s3_r;
  logic lvl_r;

  // Decoded write strobes
  logic wr_ctrl;
  assign wr_ctrl = reg_wr && (reg_addr == `TMO_ADDR_CTRL);

  // Mode decode
  logic is_sw;   // Software-start one-shot
  logic is_eos;  // Edge-triggered one-shot
  logic is_ehl;  // Edge hardware-limit one-shot
  logic is_les;  // Level reset, edge start one-shot
  logic is_mono; // Edge-triggered monostable
  logic is_lhl;  // Level hardware-limit one-shot
  logic is_lvl;  // Either level-reset family
  assign is_sw = (mode_r == `TMO_MODE_SW_OS);
  assign is_eos = (mode_r >= `TMO_MODE_EOS_RISE) &&
                  (mode_r <= `TMO_MODE_EOS_ANY);
  assign is_ehl = (mode_r == `TMO_MODE_EHL_RISE) ||
                  (mode_r == `TMO_MODE_EHL_FALL);
  assign is_les = (mode_r == `TMO_MODE_LES_LOW) ||
                  (mode_r == `TMO_MODE_LES_HIGH);
  assign is_mono = (mode_r >= `TMO_MODE_MONO_RISE) &&
                   (mode_r <= `TMO_MODE_MONO_ANY);
  assign is_lhl = (mode_r == `TMO_MODE_LHL_LOW) ||
                  (mode_r == `TMO_MODE_LHL_HIGH);
  assign is_lvl = is_les || is_lhl;

  // Three-stage synchroniser; only the second stage reads the first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ers_s1_r <= 1'b0;
      ers_s2_r <= 1'b0;
      ers_s3_r <= 1'b0;
    end else begin
      ers_s1_r <= external_reset_signal;
      ers_s2_r <= ers_s1_r;
      ers_s3_r <= ers_s2_r;
    end
  end

  // A change counts once stages two and three agree
  logic lvl_chg;
  logic ers_rise;
  logic ers_fall;
  assign lvl_chg = (ers_s2_r == ers_s3_r) && (ers_s2_r != lvl_r);
  assign ers_rise = lvl_chg && ers_s2_r;
  assign ers_fall = lvl_chg && !ers_s2_r;

  // Filtered level; edges are judged on the timer clock only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lvl_r <= 1'b0;
    end else if (lvl_chg) begin
      lvl_r <= ers_s2_r;
    end
  end

  // Edge and level selection per mode
  logic sel_edge; // Rising, falling or either from the low code bits
  logic hl_edge;  // Rising when code bit 0 is clear, else falling
  logic at_rst;   // Signal sits at the selected reset level
  assign sel_edge = (mode_r[0] && ers_rise) || (mode_r[1] && ers_fall);
  assign hl_edge = mode_r[0] ? ers_fall : ers_rise;
  assign at_rst = (lvl_r == mode_r[0]);

  // Start condition out of idle or a finished monostable
  logic start_ev;
  always_comb begin
    start_ev = 1'b0;
    if (st_r == tmo_pkg::TMO_IDLE) begin
      if (is_sw) begin
        start_ev = on_r;
      end else if (is_eos) begin
        start_ev = on_r && sel_edge;
      end else if (is_ehl || is_les) begin
        start_ev = on_r && hl_edge;
      end else if (is_lhl) begin
        start_ev = on_r && !at_rst;
      end
    end
    if ((st_r == tmo_pkg::TMO_IDLE || st_r == tmo_pkg::TMO_DONE) &&
        is_mono) begin
      start_ev = on_r && sel_edge;
    end
  end

  // Counting qualifiers
  logic lvl_hold; // Level modes pin the count at zero
  logic adv;      // Count may move this clock
  logic pmatch;   // Count equals the period value
  logic wmatch;   // Count equals the pulse width
  logic lim_edge; // Reset edge while a limit cycle is live
  assign lvl_hold = is_lvl && at_rst;
  assign adv = (st_r == tmo_pkg::TMO_RUN) && on_r && !lvl_hold;
  // A reset edge on the match clock wins, so the cycle is not ended
  assign pmatch = adv && !lim_edge && (count_r == period_value_r);
  assign wmatch = adv && (count_r == pulse_width_r);
  assign lim_edge = is_ehl && on_r && hl_edge &&
                    (st_r == tmo_pkg::TMO_RUN ||
                     st_r == tmo_pkg::TMO_HOLD);

  // Run-enable: software write wins over the hardware clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      on_r <= 1'b0;
    end else if (wr_ctrl) begin
      on_r <= reg_wdata[`TMO_CTRL_ON_BIT];
    end else if (pmatch && !is_mono) begin
      on_r <= 1'b0;
    end
  end

  // Mode and compare values
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_r <= `TMO_RST_MODE;
      period_value_r <= `TMO_RST_PERIOD;
      pulse_width_r <= `TMO_RST_PULSE;
    end else if (reg_wr) begin
      if (reg_addr == `TMO_ADDR_CTRL) begin
        mode_r <= reg_wdata[`TMO_CTRL_MODE_HI:`TMO_CTRL_MODE_LO];
      end
      if (reg_addr == `TMO_ADDR_PERIOD) begin
        period_value_r <= reg_wdata;
      end
      if (reg_addr == `TMO_ADDR_PULSE) begin
        pulse_width_r <= reg_wdata;
      end
    end
  end

  // Sequencer: start, run, limit hold and monostable stop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= tmo_pkg::TMO_IDLE;
      hold_r <= 2'h0;
    end else begin
      unique case (st_r)
        tmo_pkg::TMO_IDLE: begin
          if (start_ev) begin
            st_r <= tmo_pkg::TMO_RUN;
          end
        end
        tmo_pkg::TMO_RUN: begin
          if (lim_edge) begin
            // Count restarts after the fixed delay
            st_r <= tmo_pkg::TMO_HOLD;
            hold_r <= 2'(`TMO_HL_DELAY - 1);
          end else if (pmatch) begin
            // Monostable keeps run-enable and parks
            st_r <= is_mono ? tmo_pkg::TMO_DONE
                            : tmo_pkg::TMO_IDLE;
          end else if (lvl_hold) begin
            // Level modes need a fresh release to go again
            st_r <= tmo_pkg::TMO_IDLE;
          end else if (!on_r && !is_sw) begin
            // Halted: a new start event must follow
            st_r <= tmo_pkg::TMO_IDLE;
          end
        end
        tmo_pkg::TMO_HOLD: begin
          if (!on_r) begin
            st_r <= tmo_pkg::TMO_IDLE;
          end else if (lim_edge) begin
            hold_r <= 2'(`TMO_HL_DELAY - 1);
          end else if (hold_r == 2'h0) begin
            st_r <= tmo_pkg::TMO_RUN;
          end else begin
            hold_r <= hold_r - 2'h1;
          end
        end
        tmo_pkg::TMO_DONE: begin
          // A new edge or a mode change leaves the parked state
          if (start_ev || !is_mono) begin
            st_r <= start_ev ? tmo_pkg::TMO_RUN : tmo_pkg::TMO_IDLE;
          end
        end
      endcase
    end
  end

  // Count: paused while run-enable is low in software mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_r <= 8'h00;
    end else if (lvl_hold) begin
      count_r <= 8'h00;
    end else if (lim_edge) begin
      count_r <= 8'h00;
    end else if (pmatch) begin
      count_r <= 8'h00;
    end else if (adv) begin
      count_r <= count_r + 8'h01;
    end
  end

  // PWM drive: a set in the same clock wins over the width match
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwm_r <= 1'b0;
    end else if (start_ev) begin
      pwm_r <= 1'b1;
    end else if (lim_edge) begin
      pwm_r <= 1'b1;
    end else if (wmatch) begin
      pwm_r <= 1'b0;
    end
  end

  // Read data, valid only in the clock after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TMO_ADDR_CTRL: rdata_r <= {on_r, 2'h0, mode_r};
        `TMO_ADDR_PERIOD: rdata_r <= period_value_r;
        `TMO_ADDR_PULSE: rdata_r <= pulse_width_r;
        `TMO_ADDR_COUNT: rdata_r <= count_r;
        `TMO_ADDR_STATUS: rdata_r <= {pwm_r, 5'h00, st_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;
  assign pwm_drive = pwm_r;
  assign count_value = count_r;

  // Checks on the sequencer, all in the timer clock domain
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_sw_match_clear: assert property (
    (is_sw && pmatch && !reg_wr) |=> (!on_r && count_r == 8'h00 &&
      st_r == tmo_pkg::TMO_IDLE))
    else $error("software one-shot did not stop at period match");

  a_sw_pause_hold: assert property (
    (is_sw && st_r == tmo_pkg::TMO_RUN && !on_r && !reg_wr)
      |=> $stable(count_r) && st_r == tmo_pkg::TMO_RUN)
    else $error("paused count moved");

  a_width_match_off: assert property (
    (wmatch && !start_ev && !lim_edge) |=> !pwm_r)
    else $error("drive stayed on past pulse width match");

  a_start_drive_on: assert property (
    start_ev |=> (pwm_r && st_r == tmo_pkg::TMO_RUN))
    else $error("start event did not raise the drive");

  a_limit_restart: assert property (
    (lim_edge && !reg_wr) |=> (st_r == tmo_pkg::TMO_HOLD &&
      count_r == 8'h00 && pwm_r) ##1 (st_r == tmo_pkg::TMO_HOLD))
    else $error("limit reset edge did not hold for the delay");

  a_off_ignores_edge: assert property (
    (st_r == tmo_pkg::TMO_IDLE && !on_r && !reg_wr)
      |=> st_r == tmo_pkg::TMO_IDLE)
    else $error("timer started while disabled");

  a_level_held_zero: assert property (
    (lvl_hold && !reg_wr) |=> (count_r == 8'h00))
    else $error("count moved at reset level");

  a_mono_keeps_on: assert property (
    (is_mono && pmatch && !reg_wr) |=> (on_r && count_r == 8'h00 &&
      st_r == tmo_pkg::TMO_DONE))
    else $error("monostable did not park with enable set");

  a_oneshot_clear: assert property (
    (pmatch && !is_mono && !reg_wr) |=> !on_r)
    else $error("one-shot left enable set after match");

  a_mono_edge_quiet: assert property (
    (is_mono && adv && !wmatch && !reg_wr) |=> $stable(pwm_r))
    else $error("monostable drive changed mid-count");

  a_hold_count_zero: assert property (
    (st_r == tmo_pkg::TMO_HOLD) |-> (count_r == 8'h00))
    else $error("count moved during the limit restart delay");

  a_done_parked: assert property (
    (st_r == tmo_pkg::TMO_DONE) |-> (count_r == 8'h00))
    else $error("parked monostable count left zero");

  a_level_start_run: assert property (
    (is_lhl && st_r == tmo_pkg::TMO_IDLE && on_r && !at_rst)
      |=> (st_r == tmo_pkg::TMO_RUN && pwm_r))
    else $error("level limit start did not raise the drive");

endmodule // tmo_timer

`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmo_regs.svh"

module testbench;
  localparam logic [7:0] PER = 8'h0c; // Period used by most tests
  localparam logic [7:0] PUL = 8'h05; // Pulse width used by most tests
  logic sys_clk, rst, reg_wr, reg_rd, ext_req, pwm_drive, ext_pin;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, count_value, pulse_len;
  int n_mismatch = 0;
  int compares = 0;

  tmo_timer i_tmo_timer (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_reset_signal(ext_pin),
    .pwm_drive(pwm_drive), .count_value(count_value));
  tmo_far_side i_tmo_far_side (.sys_clk(sys_clk), .rst(rst),
    .level_req(ext_req), .pwm_drive(pwm_drive),
    .external_reset_signal(ext_pin), .pulse_len_r(pulse_len));

  // Free-running timer clock, 100 ns
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Every step ends 1 ns past the edge, so outputs have settled
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobe dropped a cycle before any next strobe may rise
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tick();
    reg_wr <= 1'b0;
    tick();
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick();
    reg_rd <= 1'b0;
    check(reg_rdata, exp);
    tick();
  endtask

  // Bounded wait for a count value, then compare it
  task automatic wait_cnt(input logic [7:0] v);
    for (int i = 0; i < 80 && count_value !== v; i++) tick();
    check(count_value, v);
  endtask

  task automatic ticks(input int n);
    repeat (n) tick();
  endtask

  // One full one-shot or monostable cycle started by moving l0 to l1
  task automatic os_cycle(input logic [4:0] m, input logic l0, l1);
    logic mono;
    mono = (m[4:2] == 3'b100);
    ext_req <= l0;
    ticks(6);
    wr(`TMO_ADDR_CTRL, {3'b100, m});
    ticks(6);
    check(count_value, 8'h00);
    ext_req <= l1;
    wait_cnt(PER);
    tick();
    check(count_value, 8'h00);
    rd(`TMO_ADDR_CTRL, {mono, 2'b00, m});
    check({7'h00, pwm_drive}, 8'h00);
    check(pulse_len, PUL + 8'h01);
    ticks(4);
    check(count_value, 8'h00);
    wr(`TMO_ADDR_CTRL, {3'b000, m});
    ext_req <= l0;
    ticks(6);
    ext_req <= l1;
    ticks(6);
    check(count_value, 8'h00);
    check({7'h00, pwm_drive}, 8'h00);
  endtask

  // Software pause in mid-cycle, then resume to the period match
  task automatic halt_resume(input logic [4:0] m, input logic edge_mode);
    logic [7:0] hold;
    ext_req <= 1'b0;
    ticks(6);
    wr(`TMO_ADDR_CTRL, {3'b100, m});
    if (edge_mode) ext_req <= 1'b1;
    wait_cnt(8'h02);
    wr(`TMO_ADDR_CTRL, {3'b000, m});
    hold = count_value;
    ticks(4);
    check(count_value, hold);
    check({7'h00, pwm_drive}, 8'h01);
    wr(`TMO_ADDR_CTRL, {3'b100, m});
    if (edge_mode) begin
      ticks(6);
      check(count_value, hold);
      ext_req <= 1'b0;
      ticks(4);
      ext_req <= 1'b1;
    end
    wait_cnt(PER);
    tick();
    check(count_value, 8'h00);
    rd(`TMO_ADDR_CTRL, {3'b000, m});
    ticks(8);
    check(count_value, 8'h00);
    check({7'h00, pwm_drive}, 8'h00);
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run is under 1000 cycles; give it twenty times that
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    ext_req = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst <= 1'b0;
    tick();
    // Reset values, read-only count, unmapped address
    rd(`TMO_ADDR_CTRL, 8'h00);
    rd(`TMO_ADDR_PERIOD, `TMO_RST_PERIOD);
    rd(`TMO_ADDR_PULSE, `TMO_RST_PULSE);
    rd(`TMO_ADDR_STATUS, 8'h00);
    rd(3'h7, 8'h00);
    wr(`TMO_ADDR_COUNT, 8'h55);
    rd(`TMO_ADDR_COUNT, 8'h00);
    wr(`TMO_ADDR_PERIOD, PER);
    wr(`TMO_ADDR_PULSE, PUL);
    rd(`TMO_ADDR_PERIOD, PER);
    halt_resume(`TMO_MODE_SW_OS, 1'b0);
    halt_resume(`TMO_MODE_EOS_RISE, 1'b1);
    // Every edge- and level-started mode, with its start transition
    os_cycle(`TMO_MODE_EOS_RISE, 1'b0, 1'b1);
    os_cycle(5'h0a, 1'b1, 1'b0);
    os_cycle(`TMO_MODE_EOS_ANY, 1'b1, 1'b0);
    os_cycle(`TMO_MODE_EHL_RISE, 1'b0, 1'b1);
    os_cycle(`TMO_MODE_EHL_FALL, 1'b1, 1'b0);
    os_cycle(`TMO_MODE_LES_LOW, 1'b0, 1'b1);
    os_cycle(`TMO_MODE_LES_HIGH, 1'b1, 1'b0);
    os_cycle(`TMO_MODE_MONO_RISE, 1'b0, 1'b1);
    os_cycle(5'h12, 1'b1, 1'b0);
    os_cycle(`TMO_MODE_MONO_ANY, 1'b0, 1'b1);
    os_cycle(`TMO_MODE_LHL_LOW, 1'b0, 1'b1);
    os_cycle(`TMO_MODE_LHL_HIGH, 1'b1, 1'b0);
    // Level limit: signal released first, enable starts the count
    ext_req <= 1'b1;
    ticks(6);
    wr(`TMO_ADDR_CTRL, 8'h96);
    wait_cnt(8'h01);
    check({7'h00, pwm_drive}, 8'h01);
    ext_req <= 1'b0;
    wait_cnt(8'h00);
    wr(`TMO_ADDR_CTRL, 8'h00);
    // Longer period so a reset edge lands before the match
    wr(`TMO_ADDR_PERIOD, 8'h30);
    wr(`TMO_ADDR_CTRL, {3'b100, `TMO_MODE_EHL_RISE});
    ext_req <= 1'b1;
    wait_cnt(PUL + 8'h02);
    check({7'h00, pwm_drive}, 8'h00);
    ext_req <= 1'b0;
    ticks(4);
    ext_req <= 1'b1;
    wait_cnt(8'h00);
    check({7'h00, pwm_drive}, 8'h01);
    rd(`TMO_ADDR_STATUS, 8'h82);
    check(count_value, 8'h00);
    wait_cnt(8'h01);
    wr(`TMO_ADDR_CTRL, 8'h00);
    // Level reset in mid-run forces the count back to zero
    ext_req <= 1'b0;
    ticks(6);
    wr(`TMO_ADDR_CTRL, {3'b100, `TMO_MODE_LES_LOW});
    ext_req <= 1'b1;
    wait_cnt(8'h03);
    ext_req <= 1'b0;
    wait_cnt(8'h00);
    ticks(4);
    check(count_value, 8'h00);
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire

// >>> test/tmo_far_side.sv
`timescale 1ns/1ns
`default_nettype none

// Far side: external start/reset source and PWM compare watcher
module tmo_far_side (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic level_req,
  input wire logic pwm_drive,
  output logic external_reset_signal,
  output tmo_pkg::tmo_byte_t pulse_len_r
);
  tmo_pkg::tmo_byte_t run_r; // Cycles high in the current pulse

  // Pin moves on the falling edge, away from the timer's sampling edge
  always_ff @(negedge sys_clk) begin
    external_reset_signal <= level_req;
  end

  // Length of the last finished pulse, as a compare unit would see it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_r <= 8'h00;
      pulse_len_r <= 8'h00;
    end else if (pwm_drive) begin
      run_r <= run_r + 8'h01;
    end else if (run_r != 8'h00) begin
      pulse_len_r <= run_r;
      run_r <= 8'h00;
    end
  end
endmodule // tmo_far_side

`default_nettype wire
